// File: sleep_wakeup_pkg.sv
// constants, register map and state type for the sleep and wake-up controller
package sleep_wakeup_pkg;

   // ------------------------------------------------------------------
   // register map (byte addresses on the bus)
   // ------------------------------------------------------------------
   localparam logic [7:0] CTRL_ADDR = 8'h00;   // control and mode bits
   localparam logic [7:0] INTEN_ADDR = 8'h04;  // per-source wake enables
   localparam logic [7:0] STATUS_ADDR = 8'h08; // power and wake status

   // ------------------------------------------------------------------
   // control register fields
   // ------------------------------------------------------------------
   localparam int CTRL_WDT_EN = 0;    // watchdog_timer enable
   localparam int CTRL_GIE = 1;       // global_interrupt_enable
   localparam int CTRL_MR_EN = 2;     // master_reset_pin function on
   localparam int CTRL_T1_ASYNC = 3;  // first_timer in asynchronous counter mode
   localparam int CTRL_RX_SSLAVE = 4; // serial receiver in synchronous slave mode
   localparam int CTRL_SSP_SLAVE = 5; // synchronous_serial_port in slave mode
   localparam int CTRL_ADC_RC = 6;    // converter clocked by its internal rc
   localparam int CTRL_WIDTH = 7;
   localparam logic [6:0] CTRL_RESET = 7'h04; // master reset pin on by default

   // ------------------------------------------------------------------
   // interrupt source positions (flags in, enables in inten)
   // ------------------------------------------------------------------
   localparam int SRC_EXT = 0;     // external_interrupt_pin
   localparam int SRC_IOC = 1;     // port-b interrupt-on-change
   localparam int SRC_CCP = 2;     // capture_compare_unit capture
   localparam int SRC_FIRST_TIMER = 3;    // first_timer overflow
   localparam int SRC_RX = 4;      // serial receive
   localparam int SRC_ADC = 5;     // conversion done
   localparam int SRC_SSP = 6;     // synchronous_serial_port
   localparam int SRC_CLOCKED = 7; // any source that needs an on-chip clock
   localparam int SRC_COUNT = 8;
   localparam logic [7:0] INTEN_RESET = 8'h00;

   // ------------------------------------------------------------------
   // status register fields
   // ------------------------------------------------------------------
   localparam int ST_PD = 0;       // power_down_flag
   localparam int ST_TO = 1;       // timeout_flag
   localparam int ST_ASLEEP = 2;   // currently in sleep
   localparam int ST_CAUSE_LO = 3; // last wake cause, two bits
   localparam logic [1:0] CAUSE_NONE = 2'h0;
   localparam logic [1:0] CAUSE_WDT = 2'h1;
   localparam logic [1:0] CAUSE_INT = 2'h2;

   // ------------------------------------------------------------------
   // core side constants
   // ------------------------------------------------------------------
   localparam int PC_WIDTH = 13;
   localparam logic [12:0] VECTOR_ADDR = 13'h0004; // interrupt vector
   localparam logic [12:0] PC_STEP = 13'h0001;     // prefetch offset

   // controller states
   typedef enum logic [1:0] {stRun, stSleep, stResume, stVector} sleep_state_t;

endpackage

// File: sleep_wakeup_control.sv
// sleep entry, wake-up and power status control with its apb register file
//
// Register access over APB and the register offsets were chosen for this implementation.
`timescale 1ns/100ps

// Notes on behaviour
// - sleep instruction enters the low-power state
// - sleep entry clears watchdog, watchdog keeps running
// - sleep entry clears the power-down flag
// - sleep entry sets the time-out flag
// - oscillator driver off while asleep
// - io pins hold their drive state asleep
// - watchdog reset never pulls master reset pin
// - wake on reset pin, watchdog or interrupt
// - pin wake resets; others resume execution
// - power-down flag set at power-up
// - watchdog wake clears the time-out flag
// - first timer wakes only as asynchronous counter
// - receiver/serial port wake only in slave modes
// - conversion wakes only with internal rc clock
// - capture, change, pin wake; clocked sources never
// - sleep prefetches the instruction at pc plus one
// - wake needs source enable, regardless of global enable
// - global enable clear: continue after sleep
// - global enable set: next instruction, then vector
// - pending flag during sleep: complete, wake immediately
// - pending before sleep: sleep acts as no-op
module sleep_wakeup_control
   import sleep_wakeup_pkg::*;
(
   // clock and power-on reset
   input wire logic clk,
   input wire logic rst,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // processor core
   input wire logic sleepExec,
   input wire logic [12:0] pcNow,
   output logic [12:0] prefetchAddr,
   output logic sleepNop,
   output logic resumeExec,
   output logic vectorBranch,
   output logic [12:0] vectorAddr,
   // wake sources
   input wire logic [7:0] intFlags,
   input wire logic masterResetPin_n,
   input wire logic wdtTimeout,
   // watchdog control
   output logic wdtRun,
   output logic wdtClear,
   // power and pins
   output logic oscDriveEn,
   output logic ioHold,
   output logic deviceReset,
   output logic resetPinOe
);

   // ------------------------------------------------------------------
   // state and registers
   // ------------------------------------------------------------------
   sleep_state_t state_q;            // controller state
   logic [6:0] ctrl_q;               // control register
   logic [7:0] intEn_q;              // wake enables
   logic pdFlag_q;                   // power_down_flag
   logic toFlag_q;                   // timeout_flag
   logic [1:0] cause_q;              // last wake cause
   logic [31:0] prdata_q;            // read data
   logic pready_q;                   // access acknowledge
   logic pslverr_q;                  // unmapped access
   logic [12:0] prefetchAddr_q;      // pc plus one
   logic sleepNop_q;                 // sleep taken as no-op
   logic resumeExec_q;               // continue program
   logic vectorBranch_q;             // jump to vector
   logic [12:0] vectorAddr_q;        // vector address
   logic wdtRun_q;                   // watchdog count enable
   logic wdtClear_q;                 // watchdog clear pulse
   logic oscDriveEn_q;               // oscillator driver on
   logic ioHold_q;                   // pin state freeze
   logic deviceReset_q;              // full device reset
   logic resetPinOe_q;               // reset pin pull-down enable

   // ------------------------------------------------------------------
   // decoded conditions
   // ------------------------------------------------------------------
   logic wdtEnable;      // watchdog enabled
   logic global_interrupt_enable;            // global interrupts on
   logic mrAsserted;     // reset pin held low with function on
   logic wdtFire;        // enabled watchdog expired
   logic enabledPend;    // any enabled flag set
   logic [7:0] wakeMask; // sources able to run without a clock
   logic wakePend;       // enabled flag from a sleep-capable source
   logic enterSleep;     // sleep really taken
   logic nopSleep;       // sleep degraded to no-op
   logic leaveSleep;     // any wake event while asleep
   logic access;         // apb access phase
   logic done;           // apb transfer completes this edge
   logic badAddr;        // address outside the map
   logic [31:0] rdMux;   // read data selection

   assign wdtEnable = ctrl_q[CTRL_WDT_EN];
   assign global_interrupt_enable = ctrl_q[CTRL_GIE];
   // the far side keeps the pin high while asleep, so low means a real reset
   assign mrAsserted = ctrl_q[CTRL_MR_EN] & ~masterResetPin_n;
   assign wdtFire = wdtEnable & wdtTimeout;
   assign enabledPend = |(intFlags & intEn_q);

   // sleep-capable sources; clocked ones are dead while the oscillator stops
   always_comb begin
      wakeMask = 8'h00;
      wakeMask[SRC_EXT] = 1'b1;
      wakeMask[SRC_IOC] = 1'b1;
      wakeMask[SRC_CCP] = 1'b1;
      wakeMask[SRC_FIRST_TIMER] = ctrl_q[CTRL_T1_ASYNC];
      wakeMask[SRC_RX] = ctrl_q[CTRL_RX_SSLAVE];
      wakeMask[SRC_SSP] = ctrl_q[CTRL_SSP_SLAVE];
      wakeMask[SRC_ADC] = ctrl_q[CTRL_ADC_RC];
      wakeMask[SRC_CLOCKED] = 1'b0;
   end

   // individual enables gate the wake, the global enable does not
   assign wakePend = |(intFlags & intEn_q & wakeMask);

   // pending enabled flag at the sleep instruction turns it into a no-op
   assign nopSleep = (state_q == stRun) & sleepExec & enabledPend
                     & ~mrAsserted & ~wdtFire;
   assign enterSleep = (state_q == stRun) & sleepExec & ~enabledPend
                       & ~mrAsserted & ~wdtFire;
   assign leaveSleep = (state_q == stSleep) & (mrAsserted | wdtFire | wakePend);

   // ------------------------------------------------------------------
   // controller state machine
   // ------------------------------------------------------------------
   // priority while asleep: reset pin, then watchdog, then interrupts
   always_ff @(posedge clk) begin
      if (rst) begin
         state_q <= stRun;
      end else begin
         case (state_q)
            stRun: begin
               if (enterSleep) begin
                  state_q <= stSleep;
               end
            end
            stSleep: begin
               if (mrAsserted) begin
                  state_q <= stRun;
               end else if (wdtFire | wakePend) begin
                  // sleep was completed on entry, wake at once
                  state_q <= stResume;
               end
            end
            stResume: begin
               // instruction after sleep runs first either way
               if (global_interrupt_enable) begin
                  state_q <= stVector;
               end else begin
                  state_q <= stRun;
               end
            end
            default: begin
               state_q <= stRun;
            end
         endcase
      end
   end

   // ------------------------------------------------------------------
   // power status flags
   // ------------------------------------------------------------------
   // power-on sets pd; only hardware changes these flags
   always_ff @(posedge clk) begin
      if (rst) begin
         pdFlag_q <= 1'b1;
      end else if (enterSleep) begin
         pdFlag_q <= 1'b0;
      end
   end

   // to is set on sleep, cleared by a watchdog expiry unless the reset pin is asserted
   always_ff @(posedge clk) begin
      if (rst) begin
         toFlag_q <= 1'b1;
      end else if (enterSleep) begin
         toFlag_q <= 1'b1;
      end else if (wdtFire & ~mrAsserted) begin
         toFlag_q <= 1'b0;
      end
   end

   // wake cause kept for software
   always_ff @(posedge clk) begin
      if (rst) begin
         cause_q <= CAUSE_NONE;
      end else if (leaveSleep & ~mrAsserted) begin
         cause_q <= wdtFire ? CAUSE_WDT : CAUSE_INT;
      end else if (enterSleep) begin
         cause_q <= CAUSE_NONE;
      end
   end

   // ------------------------------------------------------------------
   // oscillator and pin hold
   // ------------------------------------------------------------------
   // this block sits on the always-on side, so it still sees its clock
   always_ff @(posedge clk) begin
      if (rst) begin
         oscDriveEn_q <= 1'b1;
         ioHold_q <= 1'b0;
      end else if (enterSleep) begin
         oscDriveEn_q <= 1'b0;
         ioHold_q <= 1'b1;
      end else if (leaveSleep) begin
         oscDriveEn_q <= 1'b1;
         ioHold_q <= 1'b0;
      end
   end

   // ------------------------------------------------------------------
   // watchdog control
   // ------------------------------------------------------------------
   // clear on entry with the watchdog enabled and on every wake; run is never gated by sleep
   always_ff @(posedge clk) begin
      if (rst) begin
         wdtClear_q <= 1'b0;
         wdtRun_q <= 1'b0;
      end else begin
         wdtClear_q <= (enterSleep & wdtEnable) | leaveSleep;
         wdtRun_q <= wdtEnable;
      end
   end

   // ------------------------------------------------------------------
   // resets
   // ------------------------------------------------------------------
   // reset pin gives a full reset, watchdog while awake too
   always_ff @(posedge clk) begin
      if (rst) begin
         deviceReset_q <= 1'b0;
      end else begin
         deviceReset_q <= mrAsserted | ((state_q != stSleep) & wdtFire);
      end
   end

   // the reset pin is input only: a watchdog reset stays internal
   always_ff @(posedge clk) begin
      if (rst) begin
         resetPinOe_q <= 1'b0;
      end else begin
         resetPinOe_q <= 1'b0;
      end
   end

   // ------------------------------------------------------------------
   // core handshake
   // ------------------------------------------------------------------
   // next word is fetched while sleep executes
   always_ff @(posedge clk) begin
      if (rst) begin
         prefetchAddr_q <= 13'h0000;
      end else if ((state_q == stRun) & sleepExec) begin
         prefetchAddr_q <= pcNow + PC_STEP;
      end
   end

   // single-cycle notices to the core
   always_ff @(posedge clk) begin
      if (rst) begin
         sleepNop_q <= 1'b0;
         resumeExec_q <= 1'b0;
         vectorBranch_q <= 1'b0;
         vectorAddr_q <= 13'h0000;
      end else begin
         sleepNop_q <= nopSleep;
         resumeExec_q <= (state_q == stResume);
         vectorBranch_q <= (state_q == stVector);
         vectorAddr_q <= VECTOR_ADDR;
      end
   end

   // ------------------------------------------------------------------
   // apb slave
   // ------------------------------------------------------------------
   assign access = psel & penable;
   assign done = access & pready_q;
   assign badAddr = (paddr != CTRL_ADDR) & (paddr != INTEN_ADDR)
                    & (paddr != STATUS_ADDR);

   // read data selection, unused bits zero
   always_comb begin
      rdMux = 32'h0000_0000;
      if (paddr == CTRL_ADDR) begin
         rdMux[6:0] = ctrl_q;
      end else if (paddr == INTEN_ADDR) begin
         rdMux[7:0] = intEn_q;
      end else if (paddr == STATUS_ADDR) begin
         rdMux[ST_PD] = pdFlag_q;
         rdMux[ST_TO] = toFlag_q;
         rdMux[ST_ASLEEP] = (state_q == stSleep);
         rdMux[ST_CAUSE_LO +: 2] = cause_q;
      end
   end

   // one wait state: answer is registered so outputs come from flops
   always_ff @(posedge clk) begin
      if (rst) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h0000_0000;
      end else begin
         pready_q <= access & ~pready_q;
         pslverr_q <= access & ~pready_q & badAddr;
         if (access & ~pready_q & ~pwrite) begin
            prdata_q <= rdMux;
         end
      end
   end

   // writes land on the completing edge; status is read only
   always_ff @(posedge clk) begin
      if (rst) begin
         ctrl_q <= CTRL_RESET;
         intEn_q <= INTEN_RESET;
      end else if (done & pwrite) begin
         if (paddr == CTRL_ADDR) begin
            ctrl_q <= pwdata[6:0];
         end else if (paddr == INTEN_ADDR) begin
            intEn_q <= pwdata[7:0];
         end
      end
   end

   // ------------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------------
   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign prefetchAddr = prefetchAddr_q;
   assign sleepNop = sleepNop_q;
   assign resumeExec = resumeExec_q;
   assign vectorBranch = vectorBranch_q;
   assign vectorAddr = vectorAddr_q;
   assign wdtRun = wdtRun_q;
   assign wdtClear = wdtClear_q;
   assign oscDriveEn = oscDriveEn_q;
   assign ioHold = ioHold_q;
   assign deviceReset = deviceReset_q;
   assign resetPinOe = resetPinOe_q;

   // ------------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   logic [12:0] pcPlusOne; // helper for prefetch check
   assign pcPlusOne = pcNow + PC_STEP;

   property p_sleep_entry;
      enterSleep |=> (state_q == stSleep) && !pdFlag_q && toFlag_q && ioHold_q
                     && !oscDriveEn_q;
   endproperty
   a_sleep_entry: assert property (p_sleep_entry) else $error("sleep entry wrong");

   property p_wdt_clear;
      (enterSleep && wdtEnable) |=> wdtClear_q && wdtRun_q;
   endproperty
   a_wdt_clear: assert property (p_wdt_clear) else $error("watchdog not cleared");

   property p_osc_off;
      (state_q == stSleep) |-> !oscDriveEn_q && ioHold_q;
   endproperty
   a_osc_off: assert property (p_osc_off) else $error("clock on while asleep");

   property p_pin_never;
      wdtFire |=> !resetPinOe_q [*2];
   endproperty
   a_pin_never: assert property (p_pin_never) else $error("reset pin driven");

   property p_wdt_wake;
      ((state_q == stSleep) && !mrAsserted && wdtFire) |=>
         !toFlag_q && (state_q == stResume) ##1 resumeExec_q;
   endproperty
   a_wdt_wake: assert property (p_wdt_wake) else $error("watchdog wake wrong");

   property p_pin_wake;
      ((state_q == stSleep) && mrAsserted) |=> deviceReset_q && (state_q == stRun)
         && oscDriveEn_q;
   endproperty
   a_pin_wake: assert property (p_pin_wake) else $error("pin wake wrong");

   property p_masked;
      ((state_q == stSleep) && !mrAsserted && !wdtFire && !wakePend) |=>
         (state_q == stSleep);
   endproperty
   a_masked: assert property (p_masked) else $error("woken by masked source");

   property p_vector;
      ((state_q == stResume) && global_interrupt_enable) |=> resumeExec_q ##1
         (vectorBranch_q && (vectorAddr_q == VECTOR_ADDR));
   endproperty
   a_vector: assert property (p_vector) else $error("vector branch missing");

   property p_no_vector;
      ((state_q == stResume) && !global_interrupt_enable) |=> resumeExec_q ##1 !vectorBranch_q;
   endproperty
   a_no_vector: assert property (p_no_vector) else $error("unexpected vector");

   property p_nop;
      nopSleep |=> (state_q == stRun) && sleepNop_q && !wdtClear_q
         && $stable(pdFlag_q) && $stable(toFlag_q);
   endproperty
   a_nop: assert property (p_nop) else $error("nop sleep changed state");

   property p_prefetch;
      ((state_q == stRun) && sleepExec) |=> (prefetchAddr_q == $past(pcPlusOne));
   endproperty
   a_prefetch: assert property (p_prefetch) else $error("prefetch address wrong");

   property p_clocked_src;
      ((state_q == stSleep) && !mrAsserted && !wdtFire
         && ((intFlags & intEn_q & ~(8'h01 << SRC_CLOCKED)) == 8'h00)) |=>
         (state_q == stSleep);
   endproperty
   a_clocked_src: assert property (p_clocked_src) else $error("clocked source woke");

   c_entry: cover property (enterSleep ##[1:50] resumeExec_q);
   c_vector: cover property (vectorBranch_q);
   c_nop: cover property (sleepNop_q);
   c_pin: cover property ((state_q == stSleep) ##1 deviceReset_q);

endmodule

// File: core_side_model.sv
// behavioural core, watchdog and wake-source model facing the controller
`timescale 1ns/100ps
module core_side_model
   import sleep_wakeup_pkg::*;
#(
   parameter int WDT_LIMIT = 30 // short watchdog span keeps the run brief
)
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // commands from the bench
   input wire logic doSleep,
   input wire logic [12:0] sleepPc,
   input wire logic [7:0] setFlags,
   input wire logic wdtArm,
   input wire logic pinLow,
   // watchdog control from the controller
   input wire logic wdtRun,
   input wire logic wdtClear,
   // towards the controller
   output logic sleepExec,
   output logic [12:0] pcNow,
   output logic [7:0] intFlags,
   output logic wdtTimeout,
   output logic masterResetPin_n
);
   logic [7:0] wdtCount_q; // watchdog count
   // core pulses sleep; address toggles outside the pulse so stale values never match
   always_ff @(posedge clk) begin
      sleepExec <= doSleep & ~rst;
      pcNow <= rst ? 13'h0 : (doSleep ? sleepPc : ~pcNow);
      intFlags <= rst ? 8'h00 : setFlags;
      masterResetPin_n <= rst | ~pinLow;
   end
   // watchdog runs while enabled and armed, restarts on a clear pulse
   always_ff @(posedge clk) begin
      wdtTimeout <= 1'b0;
      if (rst || wdtClear) begin
         wdtCount_q <= 8'h00;
      end else if (wdtCount_q == 8'(WDT_LIMIT)) begin
         wdtCount_q <= 8'h00;
         wdtTimeout <= 1'b1;
      end else if (wdtRun && wdtArm) begin
         wdtCount_q <= wdtCount_q + 8'h01;
      end
   end
endmodule

// File: sleep_wakeup_control_tb_top.sv
// self-checking bench for the sleep and wake-up controller
`timescale 1ns/100ps
module sleep_wakeup_control_tb_top;
   import sleep_wakeup_pkg::*;
   logic clk, rst, psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr, intFlags, setFlags;
   logic [31:0] pwdata, prdata, rd;
   logic sleepExec, sleepNop, resumeExec, vectorBranch, doSleep, wdtArm, pinLow;
   logic [12:0] pcNow, prefetchAddr, vectorAddr, sleepPc, pc;
   logic masterResetPin_n, wdtTimeout, wdtRun, wdtClear, oscDriveEn, ioHold;
   logic deviceReset, resetPinOe, global_interrupt_enable, hit, pe;
   int err_count, samples_checked, seed, k;
   sleep_wakeup_control i_dut (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .sleepExec, .pcNow, .prefetchAddr, .sleepNop,
      .resumeExec, .vectorBranch, .vectorAddr, .intFlags, .masterResetPin_n,
      .wdtTimeout, .wdtRun, .wdtClear, .oscDriveEn, .ioHold, .deviceReset, .resetPinOe);
   core_side_model i_core (.clk, .rst, .doSleep, .sleepPc, .setFlags, .wdtArm, .pinLow,
      .wdtRun, .wdtClear, .sleepExec, .pcNow, .intFlags, .wdtTimeout, .masterResetPin_n);
   // ------------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_count++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic print_verdict;
      $display("checks %0d errors %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   // one apb transfer, entered just after a rising edge; waits for pready
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) check(32'h0, 32'h1);
      rd = prdata;
      pe = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // one idle edge, so a following call never reassigns psel in this step
      @(posedge clk);
   endtask
   // one-cycle sleep pulse at pc a; only the source loop checks the prefetch of the next word
   task automatic goSleep(input logic [12:0] a);
      doSleep <= 1'b1;
      sleepPc <= a;
      @(posedge clk);
      doSleep <= 1'b0;
   endtask
   // bounded wait for a resume pulse or a device reset
   task automatic waitFor(input logic rstEvt, output logic got);
      got = 1'b0;
      for (int n = 0; n < 60 && !got; n++) begin
         @(posedge clk);
         got = rstEvt ? (deviceReset === 1'b1) : (resumeExec === 1'b1);
      end
   endtask
   function automatic logic expWake(input int s, input logic m);
      if (s <= SRC_CCP) return 1'b1;
      if (s == SRC_CLOCKED) return 1'b0;
      return m;
   endfunction
   // mode sources: m set gives only their own mode bit, m clear every other; other sources: all mode bits or none
   function automatic logic [31:0] modeCtrl(input int s, input logic m);
      int b;
      logic [31:0] c;
      b = (s == SRC_FIRST_TIMER) ? CTRL_T1_ASYNC : (s == SRC_RX) ? CTRL_RX_SSLAVE :
          (s == SRC_ADC) ? CTRL_ADC_RC : (s == SRC_SSP) ? CTRL_SSP_SLAVE : -1;
      c = 32'h78;
      if (b >= 0) c = m ? (32'h1 << b) : (c & ~(32'h1 << b));
      else if (!m) c = 32'h0;
      return c | 32'h4;
   endfunction
   // ------------------------------------------------------------------
   // clock, watchdog and main sequence
   // ------------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   initial begin
      #200000;
      err_count++;
      print_verdict;
   end
   initial begin
      seed = 32'h0000_c792;
      {rst, psel, penable, pwrite, doSleep, wdtArm, pinLow} = 7'h40;
      {paddr, pwdata, setFlags, sleepPc} = '0;
      tick(20);
      rst <= 1'b0;
      tick(1);
      apb(1'b0, CTRL_ADDR, 32'h0);
      check(rd, 32'(CTRL_RESET));
      apb(1'b0, INTEN_ADDR, 32'h0);
      check(rd, 32'(INTEN_RESET));
      apb(1'b1, STATUS_ADDR, 32'h0);
      apb(1'b0, STATUS_ADDR, 32'h0);
      check(rd, 32'h3);
      apb(1'b0, 8'h0C, 32'h0);
      check(32'(pe), 32'h1);
      check(rd, 32'h0);
      // enabled flag already pending: sleep must do nothing
      apb(1'b1, CTRL_ADDR, 32'h5);
      apb(1'b1, INTEN_ADDR, 32'h1);
      setFlags <= 8'h01;
      tick(2);
      goSleep(13'h0);
      tick(2);
      check(32'({sleepNop, oscDriveEn, wdtClear}), 32'h6);
      setFlags <= 8'h00;
      apb(1'b0, STATUS_ADDR, 32'h0);
      check(rd & 32'h7, 32'h3);
      // every source in both mode settings, random global enable
      for (k = 0; k < 16; k++) begin
         global_interrupt_enable = 1'($random(seed));
         apb(1'b1, CTRL_ADDR, modeCtrl(k / 2, k % 2 == 1) | {30'h0, global_interrupt_enable, 1'b0});
         apb(1'b1, INTEN_ADDR, 32'h1 << (k / 2));
         pc = 13'($random(seed));
         goSleep(pc);
         tick(2);
         check(32'({oscDriveEn, ioHold}), 32'h1);
         check(32'(prefetchAddr), 32'(13'(pc + PC_STEP)));
         setFlags <= 8'($random(seed)) | (8'h1 << (k / 2));
         waitFor(1'b0, hit);
         check(32'(hit), 32'(expWake(k / 2, k % 2 == 1)));
         setFlags <= 8'h00;
         if (hit) begin
            tick(1);
            check(32'({vectorBranch, vectorAddr}), 32'({global_interrupt_enable, VECTOR_ADDR}));
            check(32'({oscDriveEn, ioHold}), 32'h2);
            apb(1'b0, STATUS_ADDR, 32'h0);
            check(rd & 32'h1F, 32'h12);
         end else begin
            pinLow <= 1'b1;
            waitFor(1'b1, hit);
            pinLow <= 1'b0;
            check(32'(hit), 32'h1);
            tick(4);
         end
      end
      // watchdog wake: no pin drive, time-out flag cleared
      apb(1'b1, CTRL_ADDR, 32'h5);
      apb(1'b1, INTEN_ADDR, 32'h0);
      wdtArm <= 1'b1;
      goSleep(pc);
      tick(2);
      check(32'({wdtClear, wdtRun, oscDriveEn}), 32'h6);
      waitFor(1'b0, hit);
      wdtArm <= 1'b0;
      check(32'({hit, resetPinOe, deviceReset}), 32'h4);
      apb(1'b0, STATUS_ADDR, 32'h0);
      check(rd & 32'h1F, 32'h08);
      print_verdict;
   end
endmodule
